// >>> uqes_pkg.sv
package uqes_pkg;
    // ---------------------------------------------------------------
    // register bus geometry and register indices
    // ---------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CNT_W = 32;
    localparam logic [11:0] IDX_EVSEL = 12'h300;
    localparam logic [11:0] IDX_FILTER = 12'h301;
    localparam logic [11:0] IDX_COUNT = 12'h302;
    localparam logic [11:0] IDX_STATUS = 12'h303;
    // event select field positions
    localparam int EVSEL_CODE_LSB = 0;
    localparam int EVSEL_UMASK_LSB = 8;
    localparam int EVSEL_THR_LSB = 16;
    localparam int EVSEL_EN_BIT = 24;
    localparam logic [31:0] EVSEL_RST = 32'h0000_0000;
    localparam logic [7:0] FILTER_RST = 8'h00;
    // ---------------------------------------------------------------
    // event codes
    // ---------------------------------------------------------------
    localparam logic [7:0] EV_RT_OCCUP = 8'h02;
    localparam logic [7:0] EV_DATA_IN = 8'h04;
    localparam logic [7:0] EV_DATA_OUT = 8'h05;
    localparam logic [7:0] EV_LOCAL_REPLY = 8'h06;
    localparam logic [7:0] EV_REMOTE_REPLY = 8'h07;
    localparam logic [7:0] EV_SNOOP_MOVE = 8'h0c;
    // snoop move subselect bits
    localparam int UM_TO_SHARED = 0;
    localparam int UM_TO_INVALID = 1;
    localparam int UM_SHARED_FILT = 2;
    localparam int UM_INVALID_FILT = 3;
    // filter nibbles and original-state one-hot order m, e, s, f
    localparam int FILT_SHARED_LSB = 0;
    localparam int FILT_INVALID_LSB = 4;
    localparam int ORIG_M = 0;
    localparam int ORIG_E = 1;
    localparam int ORIG_S = 2;
    localparam int ORIG_F = 3;
    // snoop reply kind bits, equal to the reply subselect bits
    localparam int RPL_W = 6;
    localparam int RPL_ABSENT = 0;
    localparam int RPL_SHARED = 1;
    localparam int RPL_FWD_SHARED = 2;
    localparam int RPL_FWD_INVAL = 3;
    localparam int RPL_CONFLICT = 4;
    localparam int RPL_WRITEBACK = 5;
    // ---------------------------------------------------------------
    // monitored widths
    // ---------------------------------------------------------------
    localparam int IMPORT_W = 5;
    localparam int EXPORT_W = 3;
    localparam int RT_STAGES = 4;
    localparam int RT_OCC_W = 6;
    localparam int PPT_W = 8;
    typedef enum logic [2:0] {
        LINE_ABSENT, LINE_SHARED, LINE_EXCL, LINE_MOD, LINE_FWD
    } line_state_t;
endpackage : uqes_pkg

// >>> snoop_if.sv
`timescale 1ns/1ns
`default_nettype none
// snoop reply and line move, one pulse per answered snoop
interface snoop_if;
    import uqes_pkg::*;
    logic valid; // reply issued this cycle
    logic local_home; // line is locally homed
    logic [RPL_W-1:0] kind; // one-hot reply kind
    logic to_shared; // line moved to shared
    logic to_invalid; // line moved to invalid
    logic [3:0] orig; // one-hot original state
    logic writeback; // line written back to memory
    logic forward; // line data forwarded
    modport responder (
        output valid, local_home, kind, to_shared,
        output to_invalid, orig, writeback, forward
    );
    modport monitor (
        input valid, local_home, kind, to_shared,
        input to_invalid, orig, writeback, forward
    );
endinterface : snoop_if
`default_nettype wire

// >>> snoop_responder.sv
`timescale 1ns/1ns
`default_nettype none
module snoop_responder
    import uqes_pkg::*;
(
    input wire logic clk_i, // core clock
    input wire logic rst_b_i, // sync reset, low
    input wire logic req_i, // snoop request pulse
    input wire logic rfo_i, // request is read for ownership
    input wire logic local_i, // line locally homed
    input wire logic conflict_i, // conflicting request seen
    input wire line_state_t state_i, // cache lookup result
    snoop_if.responder rsp // reply toward monitor and pins
);
    // ---------------------------------------------------------------
    // reply decode
    // ---------------------------------------------------------------
    logic [RPL_W-1:0] kind_next; // reply kind
    logic [3:0] orig_next; // original state
    logic hit_next; // line present
    logic wb_next; // write back
    logic fwd_next; // forward data
    always_comb begin
        kind_next = '0;
        orig_next = 4'h0;
        hit_next = 1'b0;
        wb_next = 1'b0;
        fwd_next = 1'b0;
        if (conflict_i) begin
            kind_next[RPL_CONFLICT] = 1'b1;
        end else begin
            unique case (state_i)
                LINE_SHARED, LINE_FWD: begin
                    kind_next[RPL_SHARED] = 1'b1;
                    orig_next[state_i == LINE_FWD ? ORIG_F : ORIG_S] = 1'b1;
                    hit_next = 1'b1;
                end
                LINE_EXCL: begin
                    kind_next[RPL_FWD_SHARED] = 1'b1;
                    orig_next[ORIG_E] = 1'b1;
                    hit_next = 1'b1;
                    fwd_next = 1'b1;
                end
                LINE_MOD: begin
                    // an rfo owner rewrites the line soon: skip the write
                    kind_next[RPL_FWD_INVAL] = rfo_i;
                    kind_next[RPL_WRITEBACK] = !rfo_i;
                    wb_next = !rfo_i;
                    orig_next[ORIG_M] = 1'b1;
                    hit_next = 1'b1;
                    fwd_next = 1'b1;
                end
                default: begin
                    // absent and unused codes
                    kind_next[RPL_ABSENT] = 1'b1;
                end
            endcase
        end
    end
    // ---------------------------------------------------------------
    // registered reply, one cycle after the request
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rsp.valid <= 1'b0;
            rsp.local_home <= 1'b0;
            rsp.kind <= '0;
            rsp.to_shared <= 1'b0;
            rsp.to_invalid <= 1'b0;
            rsp.orig <= 4'h0;
            rsp.writeback <= 1'b0;
            rsp.forward <= 1'b0;
        end else begin
            rsp.valid <= req_i;
            rsp.local_home <= req_i && local_i;
            rsp.kind <= req_i ? kind_next : '0;
            rsp.to_shared <= req_i && hit_next && !rfo_i;
            rsp.to_invalid <= req_i && hit_next && rfo_i;
            rsp.orig <= req_i ? orig_next : 4'h0;
            rsp.writeback <= req_i && wb_next;
            rsp.forward <= req_i && fwd_next;
        end
    end
endmodule : snoop_responder
`default_nettype wire

// >>> uncore_queue_event_select.sv
// What this block does
// - threshold 32 counts full, 1 counts busy
// - code 04 counts import cycles per source
// - code 05 counts export cycles per port
// - port events count busy cycles, not bytes
// - queue answers interconnect snoops, tracker entries
// - modified read hit replies and writes back
// - modified rfo hit forwards, no writeback
// - code 06 counts local home replies
// - code 07 counts remote home replies
// - subselect 01 shared, 02 invalid moves
// - subselect 04 filters shared moves by origin
// - subselect 08 filters invalid moves by origin
`timescale 1ns/1ns
`default_nettype none
module uncore_queue_event_select
    import uqes_pkg::*;
#(
    parameter int CW = CNT_W // event counter width
) (
    input wire logic CORE_CLK_I, // uncore clock
    input wire logic RST_B_I, // sync reset, low
    input wire logic [ADDR_W-1:0] REG_ADDR_I, // register index
    input wire logic [DATA_W-1:0] REG_WDATA_I, // write data
    input wire logic REG_WR_I, // write strobe
    input wire logic REG_RD_I, // read strobe
    output logic [DATA_W-1:0] REG_RDATA_O, // read data
    input wire logic [RT_STAGES-1:0][RT_OCC_W-1:0] RT_OCC_I, // stages
    input wire logic [IMPORT_W-1:0] IMPORT_BUSY_I, // import ports
    input wire logic [EXPORT_W-1:0] EXPORT_BUSY_I, // export ports
    input wire logic SNP_REQ_I, // snoop request pulse
    input wire logic SNP_RFO_I, // request is rfo
    input wire logic SNP_LOCAL_I, // line locally homed
    input wire logic SNP_CONFLICT_I, // conflict seen
    input wire line_state_t SNP_LINE_STATE_I, // lookup result
    output logic SNP_REPLY_VALID_O, // reply pulse
    output logic SNP_REPLY_LOCAL_O, // reply for local home
    output logic [RPL_W-1:0] SNP_REPLY_KIND_O, // one-hot kind
    output logic SNP_WRITEBACK_O, // writeback pulse
    output logic SNP_FORWARD_O, // forward pulse
    output logic [PPT_W-1:0] PPT_COUNT_O, // probe tracker entries
    output logic [CW-1:0] EVENT_COUNT_O // counter value
);
    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [31:0] evsel_reg; // event select
    logic [7:0] filter_reg; // snoop move filter
    logic [CW-1:0] count_reg; // event counter
    logic [CW-1:0] count_next; // next counter value
    logic [PPT_W-1:0] ppt_reg; // probe tracker entries
    logic [DATA_W-1:0] rdata_reg; // read answer
    logic [DATA_W-1:0] rdata_next; // read mux
    logic [7:0] code; // selected event code
    logic [7:0] umask; // selected subselect
    logic [7:0] thr; // occupancy threshold
    logic count_en; // counting enabled
    logic [CW-1:0] inc; // amount to add this cycle
    snoop_if rsp (); // reply from responder

    assign code = evsel_reg[EVSEL_CODE_LSB +: 8];
    assign umask = evsel_reg[EVSEL_UMASK_LSB +: 8];
    assign thr = evsel_reg[EVSEL_THR_LSB +: 8];
    assign count_en = evsel_reg[EVSEL_EN_BIT];

    // ---------------------------------------------------------------
    // snoop responder
    // ---------------------------------------------------------------
    // the responder keeps the coherence decision apart from the
    // counting, so the reply pins never wait for event selection
    snoop_responder u_resp (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .req_i(SNP_REQ_I),
        .rfo_i(SNP_RFO_I),
        .local_i(SNP_LOCAL_I),
        .conflict_i(SNP_CONFLICT_I),
        .state_i(SNP_LINE_STATE_I),
        .rsp(rsp.responder)
    );

    // reply pins come straight from the responder flops
    assign SNP_REPLY_VALID_O = rsp.valid;
    assign SNP_REPLY_LOCAL_O = rsp.local_home;
    assign SNP_REPLY_KIND_O = rsp.kind;
    assign SNP_WRITEBACK_O = rsp.writeback;
    assign SNP_FORWARD_O = rsp.forward;
    assign PPT_COUNT_O = ppt_reg;
    assign EVENT_COUNT_O = count_reg;
    assign REG_RDATA_O = rdata_reg;

    // ---------------------------------------------------------------
    // peer probe tracker occupancy
    // ---------------------------------------------------------------
    // an entry is taken with the request and freed by the reply;
    // both in one cycle leave the count as it was
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            ppt_reg <= '0;
        end else if (SNP_REQ_I && !rsp.valid) begin
            ppt_reg <= ppt_reg + 8'h01;
        end else if (!SNP_REQ_I && rsp.valid) begin
            ppt_reg <= ppt_reg - 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // read tracker stage selection
    // ---------------------------------------------------------------
    // each subselect bit watches one stage: bit 0 the whole tracker,
    // bits 1..3 the miss, cache reply and id acquired stages
    logic [RT_STAGES-1:0] stage_ge; // stage at or over threshold
    logic [RT_STAGES:0][7:0] occ_sum; // running selected sum
    assign occ_sum[0] = 8'h00;
    genvar g;
    generate
        for (g = 0; g < RT_STAGES; g++) begin : g_stage
            logic [7:0] occ; // stage count, widened
            assign occ = {2'b00, RT_OCC_I[g]};
            // 32 means full, 1 means holding any entry
            assign stage_ge[g] = umask[g] && (thr != 8'h00)
                && (occ >= thr);
            assign occ_sum[g+1] = occ_sum[g]
                + (umask[g] ? occ : 8'h00);
        end
    endgenerate

    // ---------------------------------------------------------------
    // snoop move conditions
    // ---------------------------------------------------------------
    // each filtered move has its own filter nibble, shared in bits 3..0
    // and invalid in bits 7..4, so both can be selected at one time
    logic move_plain_s; // any move to shared
    logic move_plain_i; // any move to invalid
    logic move_filt_s; // filtered move to shared
    logic move_filt_i; // filtered move to invalid
    logic move_hit; // any selected move
    assign move_plain_s = umask[UM_TO_SHARED]
        && rsp.to_shared;
    assign move_plain_i = umask[UM_TO_INVALID]
        && rsp.to_invalid;
    assign move_filt_s = umask[UM_SHARED_FILT] && rsp.to_shared
        && |(filter_reg[FILT_SHARED_LSB +: 4] & rsp.orig);
    assign move_filt_i = umask[UM_INVALID_FILT] && rsp.to_invalid
        && |(filter_reg[FILT_INVALID_LSB +: 4] & rsp.orig);
    assign move_hit = move_plain_s || move_plain_i
        || move_filt_s || move_filt_i;

    // ---------------------------------------------------------------
    // reply and port conditions
    // ---------------------------------------------------------------
    logic local_hit; // selected local home reply
    logic remote_hit; // selected remote home reply
    logic import_hit; // selected import port busy
    logic export_hit; // selected export port busy
    // composites such as 24 or 1a simply or the kind bits
    assign local_hit = rsp.valid && rsp.local_home
        && |(umask[RPL_W-1:0] & rsp.kind);
    assign remote_hit = rsp.valid && !rsp.local_home
        && |(umask[RPL_W-1:0] & rsp.kind);
    // a busy port counts one per cycle whatever it moves, so
    // 8 and 16 byte transfers look the same here
    assign import_hit = |(umask[IMPORT_W-1:0]
        & IMPORT_BUSY_I);
    assign export_hit = |(umask[EXPORT_W-1:0]
        & EXPORT_BUSY_I);

    // ---------------------------------------------------------------
    // increment selection
    // ---------------------------------------------------------------
    // threshold zero adds the summed occupancy, which
    // software divides by allocations for latency;
    // right only once the queue was drained at setup
    always_comb begin
        inc = '0;
        case (code)
            EV_RT_OCCUP: begin
                if (thr == 8'h00) begin
                    inc = CW'(occ_sum[RT_STAGES]);
                end else begin
                    inc = CW'(|stage_ge);
                end
            end
            EV_DATA_IN: begin
                inc = CW'(import_hit);
            end
            EV_DATA_OUT: begin
                inc = CW'(export_hit);
            end
            EV_LOCAL_REPLY: begin
                inc = CW'(local_hit);
            end
            EV_REMOTE_REPLY: begin
                inc = CW'(remote_hit);
            end
            EV_SNOOP_MOVE: begin
                inc = CW'(move_hit);
            end
            default: begin
                // unknown codes count nothing
                inc = '0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // event counter
    // ---------------------------------------------------------------
    // a software load wins over the count of that cycle; the
    // counter wraps silently, overflow is software's to watch
    always_comb begin
        count_next = count_reg;
        if (REG_WR_I && (REG_ADDR_I == IDX_COUNT)) begin
            count_next = REG_WDATA_I[CW-1:0];
        end else if (count_en) begin
            count_next = count_reg + inc;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // ---------------------------------------------------------------
    // event select register
    // ---------------------------------------------------------------
    // only code, subselect, threshold and enable are kept
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            evsel_reg <= EVSEL_RST;
        end else if (REG_WR_I && (REG_ADDR_I == IDX_EVSEL)) begin
            evsel_reg <= {7'h00, REG_WDATA_I[EVSEL_EN_BIT:0]};
        end
    end

    // ---------------------------------------------------------------
    // snoop move filter register
    // ---------------------------------------------------------------
    // zero suits the unfiltered moves; a filtered move with a zero
    // filter never counts
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            filter_reg <= FILTER_RST;
        end else if (REG_WR_I && (REG_ADDR_I == IDX_FILTER)) begin
            filter_reg <= REG_WDATA_I[7:0];
        end
    end

    // ---------------------------------------------------------------
    // read answer
    // ---------------------------------------------------------------
    // data stand only in the cycle after the strobe, zero otherwise;
    // unmapped indices read as zero
    always_comb begin
        rdata_next = '0;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                IDX_EVSEL: begin
                    rdata_next = evsel_reg;
                end
                IDX_FILTER: begin
                    rdata_next = {24'h000000, filter_reg};
                end
                IDX_COUNT: begin
                    rdata_next = DATA_W'(count_reg);
                end
                IDX_STATUS: begin
                    rdata_next = {24'h000000, ppt_reg};
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
endmodule : uncore_queue_event_select
`default_nettype wire

// >>> uqes_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// snoop reply and register read checks at the top ports
// ---------------------------------------------------------------
module uqes_chk
    import uqes_pkg::*;
(
    input wire logic CORE_CLK_I, // uncore clock
    input wire logic RST_B_I, // sync reset, low
    input wire logic REG_RD_I, // read strobe
    input wire logic [DATA_W-1:0] REG_RDATA_O, // read data
    input wire logic SNP_REQ_I, // snoop request pulse
    input wire logic SNP_RFO_I, // request is rfo
    input wire logic SNP_LOCAL_I, // line locally homed
    input wire logic SNP_CONFLICT_I, // conflict seen
    input wire line_state_t SNP_LINE_STATE_I, // lookup result
    input wire logic SNP_REPLY_VALID_O, // reply pulse
    input wire logic SNP_REPLY_LOCAL_O, // reply for local home
    input wire logic [RPL_W-1:0] SNP_REPLY_KIND_O, // one-hot kind
    input wire logic SNP_WRITEBACK_O, // writeback pulse
    input wire logic SNP_FORWARD_O, // forward pulse
    input wire logic [PPT_W-1:0] PPT_COUNT_O // probe tracker entries
);
    // one clock domain
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_B_I);
    // clean lookups; a conflict overrides the line state
    wire logic clean_req = SNP_REQ_I && !SNP_CONFLICT_I;
    wire logic mod_req = clean_req && SNP_LINE_STATE_I == LINE_MOD;
    a_reply_next:
    assert property (SNP_REQ_I |=> SNP_REPLY_VALID_O)
        else $error("reply missing after request");
    a_no_stray_reply:
    assert property (!SNP_REQ_I |=> !SNP_REPLY_VALID_O)
        else $error("snoop reply without request");
    a_mod_read_wb:
    assert property (mod_req && !SNP_RFO_I |=> SNP_WRITEBACK_O
        && SNP_FORWARD_O && SNP_REPLY_KIND_O == 6'h20)
        else $error("modified read hit without writeback");
    a_mod_rfo_fwd:
    assert property (mod_req && SNP_RFO_I |=> !SNP_WRITEBACK_O
        && SNP_FORWARD_O && SNP_REPLY_KIND_O == 6'h08)
        else $error("modified rfo hit wrong reply");
    a_home_flag:
    assert property (SNP_REQ_I |=> SNP_REPLY_LOCAL_O == $past(SNP_LOCAL_I))
        else $error("reply home flag wrong");
    a_conflict_kind:
    assert property (SNP_REQ_I && SNP_CONFLICT_I
        |=> SNP_REPLY_KIND_O == 6'h10 && !SNP_WRITEBACK_O)
        else $error("conflict reply kind wrong");
    a_kind_onehot:
    assert property (SNP_REPLY_VALID_O == $onehot(SNP_REPLY_KIND_O))
        else $error("reply kind not one-hot");
    a_ppt_up:
    assert property (SNP_REQ_I && !SNP_REPLY_VALID_O
        |=> PPT_COUNT_O == $past(PPT_COUNT_O) + 8'h01)
        else $error("tracker count did not rise");
    a_ppt_down:
    assert property (!SNP_REQ_I && SNP_REPLY_VALID_O
        |=> PPT_COUNT_O == $past(PPT_COUNT_O) - 8'h01)
        else $error("tracker count did not fall");
    a_rdata_idle:
    assert property (!REG_RD_I |=> REG_RDATA_O == 32'h0)
        else $error("read data outside answer cycle");
endmodule : uqes_chk
bind uncore_queue_event_select uqes_chk i_uqes_chk (.*);
`default_nettype wire

// >>> uncore_queue_event_select_tb.sv
`timescale 1ns/1ns
`default_nettype none
module uncore_queue_event_select_tb
    import uqes_pkg::*;
;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic clk = 1'b0; // uncore clock
    logic rst_b = 1'b0; // sync reset, low
    logic [ADDR_W-1:0] addr = '0; // register index
    logic [DATA_W-1:0] wdata = '0; // write data
    logic wr_s = 1'b0; // write strobe
    logic rd_s = 1'b0; // read strobe
    logic [RT_STAGES-1:0][RT_OCC_W-1:0] rt = '0; // stage occupancy
    logic [IMPORT_W-1:0] imp = '0; // import busy
    logic [EXPORT_W-1:0] exb = '0; // export busy
    logic sreq = 1'b0, srfo = 1'b0, sloc = 1'b0, scon = 1'b0; // snoop
    line_state_t sst = LINE_ABSENT; // lookup result
    logic [DATA_W-1:0] rdata; // read data
    logic [RPL_W-1:0] kind; // reply kind
    logic [31:0] evc; // event counter
    int fails = 0; // mismatches
    int checked = 0; // comparisons
    // one event per entry: {filter, threshold, subselect, code}
    logic [31:0] tab [$] = '{32'h104, 32'h204, 32'h404, 32'h804,
        32'h1004, 32'h1b04, 32'h105, 32'h205, 32'h405, 32'h605,
        32'h200102, 32'h200202, 32'h200402, 32'h200802, 32'h10102,
        32'h10202, 32'h10402, 32'h10802, 32'h106, 32'h206, 32'h406,
        32'h806, 32'h1006, 32'h2006, 32'h2406, 32'h1a06, 32'h107,
        32'h207, 32'h407, 32'h807, 32'h1007, 32'h2007, 32'h2407,
        32'h1a07, 32'h10c, 32'h20c, 32'h0100040c, 32'h0200040c,
        32'h0400040c, 32'h0800040c, 32'h1000080c, 32'h2000080c,
        32'h4000080c, 32'h8000080c};
    always #5 clk = ~clk;
    uncore_queue_event_select i_uncore_queue_event_select (
        .CORE_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s),
        .REG_RDATA_O(rdata), .RT_OCC_I(rt), .IMPORT_BUSY_I(imp),
        .EXPORT_BUSY_I(exb), .SNP_REQ_I(sreq), .SNP_RFO_I(srfo),
        .SNP_LOCAL_I(sloc), .SNP_CONFLICT_I(scon),
        .SNP_LINE_STATE_I(sst), .SNP_REPLY_VALID_O(),
        .SNP_REPLY_LOCAL_O(), .SNP_REPLY_KIND_O(kind),
        .SNP_WRITEBACK_O(), .SNP_FORWARD_O(), .PPT_COUNT_O(),
        .EVENT_COUNT_O(evc)
    );
    // ---------------------------------------------------------------
    // verdict, compare and bus tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // idle edge between strobes
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask : wr
    // data stand one cycle after the strobe
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
        @(posedge clk);
    endtask : rdchk
    // ---------------------------------------------------------------
    // expectation helpers
    // ---------------------------------------------------------------
    function automatic void snp(output logic [5:0] k, output logic sh,
        output logic inv, output logic [3:0] o);
        k = 6'h01;
        o = 4'h0;
        case (sst)
            LINE_SHARED: begin k = 6'h02; o = 4'h4; end
            LINE_EXCL: begin k = 6'h04; o = 4'h2; end
            LINE_MOD: begin k = srfo ? 6'h08 : 6'h20; o = 4'h1; end
            LINE_FWD: begin k = 6'h02; o = 4'h8; end
        endcase
        if (scon) begin
            k = 6'h10;
            o = 4'h0;
        end
        sh = sreq && o != 4'h0 && !srfo;
        inv = sreq && o != 4'h0 && srfo;
        if (!sreq) begin
            k = 6'h00;
        end
    endfunction : snp
    function automatic logic [31:0] ev_inc(input logic [31:0] e);
        logic [5:0] k;
        logic sh, inv, hit;
        logic [3:0] o;
        logic [7:0] u, f;
        u = e[15:8];
        f = e[31:24];
        hit = 1'b0;
        snp(k, sh, inv, o);
        case (e[7:0])
            EV_RT_OCCUP: for (int g = 0; g < RT_STAGES; g++) hit |= u[g] && {2'b0, rt[g]} >= e[23:16];
            EV_DATA_IN: hit = |(imp & u[4:0]);
            EV_DATA_OUT: hit = |(exb & u[2:0]);
            EV_LOCAL_REPLY: hit = sloc && |(k & u[5:0]);
            EV_REMOTE_REPLY: hit = !sloc && |(k & u[5:0]);
            EV_SNOOP_MOVE: hit = (u[0] && sh) || (u[1] && inv)
                || (u[2] && sh && |(o & f[3:0]))
                || (u[3] && inv && |(o & f[7:4]));
        endcase
        return {31'h0, hit};
    endfunction : ev_inc
    // program one event, drive traffic, compare
    task automatic run(input logic [31:0] e);
        logic [31:0] ec;
        logic [5:0] k, pk;
        logic sh, inv;
        logic [3:0] o;
        wr(IDX_FILTER, {24'h0, e[31:24]});
        wr(IDX_EVSEL, {8'h01, e[23:0]});
        wr(IDX_COUNT, 32'h0);
        ec = 32'h0;
        pk = 6'h00;
        repeat (24) begin
            for (int g = 0; g < RT_STAGES; g++) begin
                rt[g] <= 6'(($urandom % 2) ? 32 - $urandom % 2 : $urandom % 2);
            end
            imp <= 5'($urandom);
            exb <= 3'($urandom);
            sreq <= 1'($urandom);
            srfo <= 1'($urandom);
            sloc <= 1'($urandom);
            scon <= 1'($urandom % 4 == 0);
            sst <= line_state_t'(3'($urandom));
            @(negedge clk);
            chk(32'(kind), 32'(pk));
            snp(k, sh, inv, o);
            pk = k;
            ec = ec + ev_inc(e);
            @(posedge clk);
        end
        rt <= '0;
        imp <= '0;
        exb <= '0;
        sreq <= 1'b0;
        repeat (2) @(posedge clk);
        chk(evc, ec);
        rdchk(IDX_COUNT, ec);
    endtask : run
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'h67be));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdchk(IDX_EVSEL, EVSEL_RST);
        rdchk(IDX_FILTER, 32'(FILTER_RST));
        rdchk(IDX_COUNT, 32'h0);
        rdchk(IDX_STATUS, 32'h0);
        wr(12'h3ff, 32'hffff_ffff);
        rdchk(12'h3ff, 32'h0);
        wr(IDX_FILTER, 32'h0000_01a5);
        rdchk(IDX_FILTER, 32'h0000_00a5);
        wr(IDX_EVSEL, 32'hfe00_0000);
        rdchk(IDX_EVSEL, 32'h0);
        foreach (tab[i]) begin
            run(tab[i]);
        end
        // a second reset must clear the filter again
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdchk(IDX_FILTER, 32'h0);
        conclude();
    end
    initial begin
        repeat (6000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule : uncore_queue_event_select_tb
`default_nettype wire
